// ---- design/dncw_pkg.sv ----
// dncw_pkg: word indices, field positions, reset values and scale
// constants for the drive network control words.
// assumes: used by dncw_top, dncw_sat and dncw_dir, one mclk domain.
//
// Functional notes
// - feedback word is signed 16-bit two's complement
// - rated frequency reads 8192, stopped reads zero
// - reverse rotation gives a negative feedback value
// - network speeds saturate at 32767 or -32768
// - command word written only from the network
// - bit 0: ramp down stop, or run up
// - bit 1: disable inverter, or enable it
// - bit 2: oppose reference direction, or follow it
// - bit 3 switches the inch function
// - bit 4: remote mode set, local clear
// - bit 5 selects second ramp pair
// - bit 6 activates quick stop
// - bit 7 clears a present fault
// - bits 8 to 15 have no function
// - speed reference written only from the network
// - network reference used only when source selected
// - reference scale: 8192 means rated frequency
// - direction from reference sign and bit 2
`default_nettype none

package dncw_pkg;

   // word indices on the parameter access port
   localparam logic [1:0] IDX_FEEDBACK = 2'h0;
   localparam logic [1:0] IDX_COMMAND  = 2'h1;
   localparam logic [1:0] IDX_SPEEDREF = 2'h2;

   // command word field positions
   localparam int CMD_RUN_BIT    = 0;
   localparam int CMD_ENABLE_BIT = 1;
   localparam int CMD_FWD_BIT    = 2;
   localparam int CMD_INCH_BIT   = 3;
   localparam int CMD_REMOTE_BIT = 4;
   localparam int CMD_RAMP2_BIT  = 5;
   localparam int CMD_QSTOP_BIT  = 6;
   localparam int CMD_FRESET_BIT = 7;
   localparam logic [15:0] CMD_USED_MASK = 16'h00FF;

   // reset values
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] REF_RESET = 16'h0000;
   localparam logic [15:0] FB_RESET  = 16'h0000;

   // speed scale and saturation limits
   localparam logic signed [15:0] RATED_SCALE = 16'sh2000;
   localparam logic signed [15:0] SAT_MAX     = 16'sh7FFF;
   localparam logic signed [15:0] SAT_MIN     = 16'sh8000;
   localparam int SPEED_MAG_W = 20;

   // reference source code meaning "communication network"
   localparam logic [3:0] REF_SRC_NET = 4'h9;

   // who issues a parameter write
   typedef enum logic [1:0] {
      SRC_NET   = 2'h0,
      SRC_PANEL = 2'h1,
      SRC_PROG  = 2'h3
   } dncw_src_t;

endpackage : dncw_pkg

`default_nettype wire

// ---- design/dncw_sat.sv ----
// dncw_sat: clamps a wide signed speed onto the 16-bit network range.
// assumes: purely combinational, IN_W of at least 17.
`timescale 1ns/1ps
`default_nettype none

module dncw_sat #(
   parameter int IN_W = 17
) (
   // wide signed speed
   input  wire logic signed [IN_W-1:0] din,
   // clamped network word
   output logic signed [15:0]          dout
);
   import dncw_pkg::*;

   localparam logic signed [IN_W-1:0] HI = IN_W'(SAT_MAX);
   localparam logic signed [IN_W-1:0] LO = IN_W'(SAT_MIN);

   // range checks, clamp instead of wrap
   wire logic over;
   wire logic under;
   assign over  = din > HI;
   assign under = din < LO;
   assign dout  = over  ? SAT_MAX :
                  under ? SAT_MIN : din[15:0];

endmodule : dncw_sat

`default_nettype wire

// ---- design/dncw_dir.sv ----
// dncw_dir: applies the direction bit to the signed speed reference.
// assumes: purely combinational; result is in the forward frame.
`timescale 1ns/1ps
`default_nettype none

module dncw_dir (
   // network reference and direction bit
   input  wire logic signed [15:0] ref_in,
   input  wire logic               same_dir,
   // signed reference, positive is forward
   output logic signed [16:0]      ref_eff,
   output logic                    fwd
);
   import dncw_pkg::*;

   // one extra bit so that negating -32768 cannot wrap
   wire logic signed [16:0] ref_ext;
   assign ref_ext = {ref_in[15], ref_in};
   assign ref_eff = same_dir ? ref_ext : -ref_ext;

   // zero reference keeps the commanded sense
   assign fwd = (ref_in == 16'sh0000) ? same_dir
                                      : (ref_in[15] ^ same_dir);

endmodule : dncw_dir

`default_nettype wire

// ---- design/dncw_top.sv ----
// dncw_top: command word, speed reference and speed feedback words of
// a drive, with the command bits decoded for the motor control core.
// assumes: one mclk domain at 25 MHz, all inputs synchronous to it;
// the core supplies speed magnitude already on the 8192-is-rated scale.
`timescale 1ns/1ps
`default_nettype none

module dncw_top (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      reset,
   // parameter write port
   input  wire logic                      par_wr,
   input  wire dncw_pkg::dncw_src_t       par_src,
   input  wire logic [1:0]                par_addr,
   input  wire logic [15:0]               par_wdata,
   output logic                           wr_refused_q,
   // parameter read port, open to every source
   input  wire logic [1:0]                rd_addr,
   output logic [15:0]                    rd_data_q,
   // motor core status
   input  wire logic [dncw_pkg::SPEED_MAG_W-1:0] speed_mag,
   input  wire logic                      motor_reverse,
   input  wire logic                      fault_active,
   // reference source selection settings
   input  wire logic [3:0]                local_reference_source,
   input  wire logic [3:0]                remote_reference_source,
   // commands to the motor core
   output logic                           run_q,
   output logic                           enable_q,
   output logic                           forward_q,
   output logic                           inch_function_q,
   output logic                           remote_q,
   output logic                           ramp2_q,
   output logic                           quick_stop_q,
   output logic                           fault_clear_q,
   output logic                           net_ref_used_q,
   output logic signed [15:0]             motor_ref_q,
   output logic signed [15:0]             motor_speed_feedback
);
   import dncw_pkg::*;

   // stored words
   logic [15:0]        drive_command_word;
   logic [15:0]        cmd_d;
   logic signed [15:0] network_speed_reference;
   logic signed [15:0] ref_d;
   logic signed [15:0] fb_q;
   logic               refused_d;
   logic               fclr_d;
   logic [15:0]        rd_d;

   // derived reference path
   logic signed [16:0] ref_eff;
   logic               ref_fwd;
   logic signed [15:0] ref_sat;
   logic signed [SPEED_MAG_W:0] fb_wide;
   logic signed [15:0] fb_sat;
   logic [3:0]         sel_src;
   logic               use_net;
   logic signed [15:0] mref_d;
   logic               fwd_q;
   logic               used_q;
   logic signed [15:0] mref_q;

   // write decode: only the network may change the words
   // a refused write still pulses so the far side can be told why
   wire logic net_wr;
   wire logic wr_cmd;
   wire logic wr_ref;
   assign net_wr    = par_wr && (par_src == SRC_NET);
   assign wr_cmd    = net_wr && (par_addr == IDX_COMMAND);
   assign wr_ref    = net_wr && (par_addr == IDX_SPEEDREF);
   assign refused_d = par_wr && (par_src != SRC_NET);

   // next command word, reserved bits dropped
   assign cmd_d = wr_cmd ? (par_wdata & CMD_USED_MASK)
                         : drive_command_word;
   // next reference word, master encodes on the 8192 scale
   assign ref_d = wr_ref ? par_wdata : network_speed_reference;

   // one fault clear per accepted write with bit 7 set while fault_active is high
   assign fclr_d = wr_cmd && par_wdata[CMD_FRESET_BIT]
                   && fault_active;

   // feedback: sign from rotation sense, clamp at 16 bits
   // the extra top bit keeps a full 20-bit magnitude from reading negative
   assign fb_wide = motor_reverse
                    ? -$signed({1'b0, speed_mag})
                    :  $signed({1'b0, speed_mag});

   dncw_sat #(
      .IN_W (SPEED_MAG_W + 1)
   ) u_fb_sat (
      .din  (fb_wide),
      .dout (fb_sat)
   );

   // reference: direction bit applied, then clamped
   // negating -32768 gives +32768, which the clamp folds back to 32767
   dncw_dir u_dir (
      .ref_in   (network_speed_reference),
      .same_dir (drive_command_word[CMD_FWD_BIT]),
      .ref_eff  (ref_eff),
      .fwd      (ref_fwd)
   );

   dncw_sat #(
      .IN_W (17)
   ) u_ref_sat (
      .din  (ref_eff),
      .dout (ref_sat)
   );

   // reference source follows the local or remote selection
   // zero when not selected, so a stale word cannot move the motor
   assign sel_src = drive_command_word[CMD_REMOTE_BIT]
                    ? remote_reference_source
                    : local_reference_source;
   assign use_net = (sel_src == REF_SRC_NET);
   assign mref_d  = use_net ? ref_sat : 16'sh0000;

   // read multiplexer, unmapped index reads zero
   assign rd_d = (rd_addr == IDX_FEEDBACK) ? fb_q :
                 (rd_addr == IDX_COMMAND)  ? drive_command_word :
                 (rd_addr == IDX_SPEEDREF) ? network_speed_reference :
                                             16'h0000;

   // stored words and pulses
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         drive_command_word      <= CMD_RESET;
         network_speed_reference <= REF_RESET;
         fb_q                    <= FB_RESET;
         wr_refused_q            <= 1'b0;
         fault_clear_q           <= 1'b0;
      end else begin
         drive_command_word      <= cmd_d;
         network_speed_reference <= ref_d;
         fb_q                    <= fb_sat;
         wr_refused_q            <= refused_d;
         fault_clear_q           <= fclr_d;
      end
   end

   // motor reference outputs and read data
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fwd_q     <= 1'b0;
         used_q    <= 1'b0;
         mref_q    <= 16'sh0000;
         rd_data_q <= 16'h0000;
      end else begin
         fwd_q     <= ref_fwd;
         used_q    <= use_net;
         mref_q    <= mref_d;
         rd_data_q <= rd_d;
      end
   end

   // command bits straight from the stored word, except forward from the registered direction
   assign run_q           = drive_command_word[CMD_RUN_BIT];
   assign enable_q        = drive_command_word[CMD_ENABLE_BIT];
   assign inch_function_q = drive_command_word[CMD_INCH_BIT];
   assign remote_q        = drive_command_word[CMD_REMOTE_BIT];
   assign ramp2_q         = drive_command_word[CMD_RAMP2_BIT];
   assign quick_stop_q    = drive_command_word[CMD_QSTOP_BIT];
   assign forward_q       = fwd_q;
   assign net_ref_used_q  = used_q;
   assign motor_ref_q     = mref_q;
   assign motor_speed_feedback = fb_q;

   // checks on the words and commands
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   wr_refuse_stable_a: assert property (
      (par_wr && par_src != SRC_NET) |=> wr_refused_q
         && $stable(drive_command_word)
         && $stable(network_speed_reference))
      else $error("write from a non-network source changed a word");

   reserved_zero_a: assert property (
      wr_cmd |=> drive_command_word[15:8] == 8'h00)
      else $error("reserved command bits were stored");

   run_enable_a: assert property (
      wr_cmd |=> run_q == $past(par_wdata[CMD_RUN_BIT])
         && enable_q == $past(par_wdata[CMD_ENABLE_BIT]))
      else $error("run or enable does not follow the write");

   mode_bits_a: assert property (
      wr_cmd |=> {quick_stop_q, ramp2_q, remote_q, inch_function_q}
         == $past(par_wdata[6:3]))
      else $error("mode bits do not follow the write");

   fault_once_a: assert property (
      fault_clear_q |-> $past(wr_cmd && par_wdata[CMD_FRESET_BIT]
         && fault_active))
      else $error("fault clear without a network write");

   fb_scale_a: assert property (
      (speed_mag == SPEED_MAG_W'(8192) && !motor_reverse)
         |=> motor_speed_feedback == RATED_SCALE)
      else $error("rated speed does not read 8192");

   fb_reverse_a: assert property (
      (motor_reverse && speed_mag != '0)
         |=> motor_speed_feedback[15])
      else $error("reverse rotation reads non-negative");

   fb_sat_a: assert property (
      (speed_mag > SPEED_MAG_W'(32767))
         |=> motor_speed_feedback
            == ($past(motor_reverse) ? SAT_MIN : SAT_MAX))
      else $error("feedback wrapped instead of saturating");

   dir_sense_a: assert property (
      (network_speed_reference != 16'sh0000)
         |=> forward_q == ($past(network_speed_reference[15])
            ^ $past(drive_command_word[CMD_FWD_BIT])))
      else $error("direction does not match sign and bit 2");

   ref_gate_a: assert property (
      !use_net |=> motor_ref_q == 16'sh0000 && !net_ref_used_q)
      else $error("network reference used while not selected");

   ref_scale_a: assert property (
      (use_net && network_speed_reference == RATED_SCALE
         && drive_command_word[CMD_FWD_BIT])
         |=> motor_ref_q == RATED_SCALE)
      else $error("reference 8192 not passed as rated");

   // accepted writes land exactly as written, reserved bits dropped
   cmd_accept_a: assert property (
      wr_cmd |=> drive_command_word == ($past(par_wdata) & CMD_USED_MASK))
      else $error("command word does not hold the masked write");

   ref_accept_a: assert property (
      wr_ref |=> network_speed_reference == $past(par_wdata))
      else $error("speed reference does not hold the write");

   // without an accepted write the words hold still
   cmd_hold_a: assert property (
      !wr_cmd |=> $stable(drive_command_word))
      else $error("command word changed without a network write");

   ref_hold_a: assert property (
      !wr_ref |=> $stable(network_speed_reference))
      else $error("speed reference changed without a network write");

   refused_idle_a: assert property (
      !(par_wr && par_src != SRC_NET) |=> !wr_refused_q)
      else $error("refusal flagged without a refused write");

   no_fault_clr_a: assert property (
      !fault_active |=> !fault_clear_q)
      else $error("fault clear issued with no fault present");

   // read-back of each word, one cycle after the index
   rd_reserved_a: assert property (
      (rd_addr == IDX_COMMAND) |=> rd_data_q[15:8] == 8'h00)
      else $error("reserved command bits read back non-zero");

   rd_ref_a: assert property (
      (rd_addr == IDX_SPEEDREF)
         |=> rd_data_q == $past(network_speed_reference))
      else $error("speed reference read back wrong");

   rd_fb_a: assert property (
      (rd_addr == IDX_FEEDBACK)
         |=> rd_data_q == $past(motor_speed_feedback))
      else $error("feedback word read back wrong");

   // feedback sign and zero point
   fb_zero_a: assert property (
      (speed_mag == '0) |=> motor_speed_feedback == 16'sh0000)
      else $error("stopped motor does not read zero");

   fb_forward_a: assert property (
      !motor_reverse |=> !motor_speed_feedback[15])
      else $error("forward rotation reads negative");

   // reference direction, clamp and selection
   ref_neg_sat_a: assert property (
      (use_net && network_speed_reference == SAT_MIN
         && !drive_command_word[CMD_FWD_BIT])
         |=> motor_ref_q == SAT_MAX)
      else $error("negated reference wrapped instead of clamping");

   zero_dir_a: assert property (
      (network_speed_reference == 16'sh0000)
         |=> forward_q == $past(drive_command_word[CMD_FWD_BIT]))
      else $error("zero reference lost the bit 2 sense");

   ref_used_a: assert property (
      use_net |=> net_ref_used_q)
      else $error("network reference selected but not flagged");

   // main scenarios
   fault_clear_c: cover property (fault_clear_q);
   neg_sat_c: cover property (motor_speed_feedback == SAT_MIN);
   refused_c: cover property (wr_refused_q);
   net_ref_c: cover property (net_ref_used_q && !forward_q);
   pos_sat_c: cover property (motor_ref_q == SAT_MAX);

endmodule : dncw_top

`default_nettype wire

// ---- tb/dncw_net_master.sv ----
// dncw_net_master: network master model issuing parameter writes.
// assumes: mclk from the bench; tasks are called after reset release.
`timescale 1ns/1ps
`default_nettype none
module dncw_net_master (
   // clock
   input  wire logic           mclk,
   // parameter write port toward the drive
   output logic                par_wr,
   output dncw_pkg::dncw_src_t par_src,
   output logic [1:0]          par_addr,
   output logic [15:0]         par_wdata
);
   import dncw_pkg::*;
   // idle lines carry a junk pattern, never a stale write
   initial begin
      par_wr    = 1'b0;
      par_src   = SRC_PANEL;
      par_addr  = 2'h3;
      par_wdata = 16'hA5A5;
   end
   // one write: request held for one edge, then lines scrambled
   task automatic wr(input dncw_src_t s, input logic [1:0] a,
                     input logic [15:0] d);
      @(posedge mclk);
      par_wr    <= 1'b1;
      par_src   <= s;
      par_addr  <= a;
      par_wdata <= d;
      @(posedge mclk);
      par_wr    <= 1'b0;
      par_addr  <= ~a;
      par_wdata <= ~d;
   endtask : wr
endmodule : dncw_net_master
`default_nettype wire

// ---- tb/tb_drive_network_control_words.sv ----
// tb_drive_network_control_words: checks words, decoded commands,
// reference handling and feedback of dncw_top.
// assumes: dncw_pkg, the design modules and dncw_net_master compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_network_control_words;
   import dncw_pkg::*;
   logic        mclk = 1'b0;
   logic        reset, rv, rv_d, motor_reverse, fault_active, r;
   logic [1:0]  rd_addr;
   logic [19:0] speed_mag, m;
   logic [3:0]  loc_src, rem_src;
   logic [15:0] e;
   logic [31:0] x = 32'h8;
   int          n_fail = 0, cmp_count = 0, cyc = 0;
   logic [15:0] exp_q [$];
   logic        par_wr, wr_refused_q, run_q, enable_q, forward_q;
   logic        inch_function_q, remote_q, ramp2_q, quick_stop_q;
   logic        fault_clear_q, net_ref_used_q;
   dncw_src_t   par_src;
   logic [1:0]  par_addr;
   logic [15:0] par_wdata, rd_data_q, motor_ref_q, motor_speed_feedback;
   // reference table: command, reference, expected, {rem sel, fwd, used}
   logic [15:0] rf_cmd [6] = '{16'h0004, 16'h0000, 16'h0000, 16'h0004,
                               16'h0010, 16'h0014};
   logic [15:0] rf_ref [6] = '{16'h2000, 16'h2000, 16'h8000, 16'h8000,
                               16'h1000, 16'h1000};
   logic [15:0] rf_exp [6] = '{16'h2000, 16'hE000, 16'h7FFF, 16'h8000,
                               16'h0000, 16'h1000};
   logic [2:0]  rf_flg [6] = '{3'h3, 3'h1, 3'h3, 3'h1, 3'h0, 3'h7};

   always #20 mclk = ~mclk;

   dncw_net_master dncw_net_master_i (
      .mclk(mclk), .par_wr(par_wr), .par_src(par_src),
      .par_addr(par_addr), .par_wdata(par_wdata));

   dncw_top dncw_top_i (
      .mclk(mclk), .reset(reset), .par_wr(par_wr), .par_src(par_src),
      .par_addr(par_addr), .par_wdata(par_wdata),
      .wr_refused_q(wr_refused_q), .rd_addr(rd_addr),
      .rd_data_q(rd_data_q), .speed_mag(speed_mag),
      .motor_reverse(motor_reverse), .fault_active(fault_active),
      .local_reference_source(loc_src),
      .remote_reference_source(rem_src), .run_q(run_q),
      .enable_q(enable_q), .forward_q(forward_q),
      .inch_function_q(inch_function_q), .remote_q(remote_q),
      .ramp2_q(ramp2_q), .quick_stop_q(quick_stop_q),
      .fault_clear_q(fault_clear_q), .net_ref_used_q(net_ref_used_q),
      .motor_ref_q(motor_ref_q),
      .motor_speed_feedback(motor_speed_feedback));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   // decoded command outputs packed in command word bit order
   function automatic logic [15:0] cmdv();
      return {8'h00, fault_clear_q, quick_stop_q, ramp2_q, remote_q,
              inch_function_q, forward_q, enable_q, run_q};
   endfunction : cmdv

   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      cmp_count++;
      if (got !== want) begin
         n_fail++;
         $display("BAD t=%0t got %h want %h", $time, got, want);
      end
   endtask : chk

   // read request: note the expected word, monitor compares later
   task automatic rd(input logic [1:0] a, input logic [15:0] want);
      @(posedge mclk);
      rd_addr <= a;
      rv      <= 1'b1;
      exp_q.push_back(want);
      @(posedge mclk);
      rv      <= 1'b0;
   endtask : rd

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // read monitor: data stands one cycle after the sampled index
   always @(posedge mclk) begin
      if (rv_d) chk(rd_data_q, exp_q.pop_front());
      rv_d <= rv;
   end

   // hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_of_test();
      end
   end

   initial begin
      reset         = 1'b1;
      rv            = 1'b0;
      rv_d          = 1'b0;
      rd_addr       = 2'h0;
      speed_mag     = 20'h00000;
      motor_reverse = 1'b0;
      fault_active  = 1'b1;
      loc_src       = REF_SRC_NET;
      rem_src       = 4'h0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      // every index reads zero out of reset
      for (int i = 0; i < 4; i++) rd(i[1:0], 16'h0000);
      // walk each command bit with reserved bits set, fault present
      for (int i = 0; i < 8; i++) begin
         dncw_net_master_i.wr(SRC_NET, IDX_COMMAND, 16'hFF00 | (16'h1 << i));
         #1;
         chk({15'h0, fault_clear_q}, {15'h0, i == 7});
         @(posedge mclk);
         #1;
         chk(cmdv(), i == 7 ? 16'h0000 : 16'h1 << i);
         rd(IDX_COMMAND, 16'h1 << i);
      end
      // no clear without a fault
      fault_active <= 1'b0;
      dncw_net_master_i.wr(SRC_NET, IDX_COMMAND, 16'h0080);
      #1;
      chk({15'h0, fault_clear_q}, 16'h0000);
      // direction, saturation and source selection
      for (int i = 0; i < 6; i++) begin
         dncw_net_master_i.wr(SRC_NET, IDX_COMMAND, rf_cmd[i]);
         rem_src <= rf_flg[i][2] ? REF_SRC_NET : 4'h0;
         dncw_net_master_i.wr(SRC_NET, IDX_SPEEDREF, rf_ref[i]);
         @(posedge mclk);
         #1;
         chk(motor_ref_q, rf_exp[i]);
         chk({14'h0, forward_q, net_ref_used_q},
             {14'h0, rf_flg[i][1:0]});
      end
      // panel and program writes are ignored and flagged
      dncw_net_master_i.wr(SRC_NET, IDX_SPEEDREF, 16'h0800);
      dncw_net_master_i.wr(SRC_NET, IDX_FEEDBACK, 16'h1234);
      for (int i = 0; i < 4; i++) begin
         dncw_net_master_i.wr(i[0] ? SRC_PROG : SRC_PANEL,
                              i[1] ? IDX_COMMAND : IDX_SPEEDREF, 16'h1234);
         #1;
         chk({15'h0, wr_refused_q}, 16'h0001);
      end
      rd(IDX_COMMAND, 16'h0014);
      rd(IDX_SPEEDREF, 16'h0800);
      rd(IDX_FEEDBACK, 16'h0000);
      // feedback: signed, negative in reverse, clamped
      for (int i = 0; i < 12; i++) begin
         x = xs(x);
         m = i == 0 ? 20'h08000 : i == 1 ? 20'h02000 : x[19:0] >> x[23:20];
         r = i == 0 ? 1'b1 : i == 1 ? 1'b0 : x[24];
         e = r ? (m > 20'h08000 ? 16'h8000 : 16'h0000 - m[15:0])
               : (m > 20'h07FFF ? 16'h7FFF : m[15:0]);
         speed_mag     <= m;
         motor_reverse <= r;
         @(posedge mclk);
         #1;
         chk(motor_speed_feedback, e);
         rd(IDX_FEEDBACK, e);
      end
      repeat (3) @(posedge mclk);
      end_of_test();
   end
endmodule : tb_drive_network_control_words
`default_nettype wire
